//--- hdl/pd_handshake.sv
// Purpose: buffered, host controlled process data exchange with toggle handshake
// Assumes: host on APB; network side is a plain valid/data port
// Notes: input and output images each one 32-bit word
//
// Overview of operation
// - Comm channel n uses DMA channel 2n for input, 2n+1 for output.
// - DMA offered only when attached as a PCI card, else shared memory.
// - Input and output handshakes run independently with separate bit pairs.
// - Host input toggle copies latest internal input buffer to shared image.
// - Host output toggle copies shared output image into internal buffer.
// - After the copy the device toggles its bit, returning ownership.
// - Internal input buffer refreshes on every valid network cycle.
// - Internal output buffer transmits continuously until replaced.
// - Unsynchronised cycles may lose output or input data; allowed.
// - Slave on network fault freezes input and clears communicating.
// - Provider status precedes each image: four bytes, one byte or none.
// - Status size changes only on a new configuration download.
// - Status low byte generic, upper bytes fieldbus dependent.
// - Low four status bits are fieldbus specific, not interpreted.
// - Master local status good for healthy slaves; remote passes through.
// - Slave local status good only with fault-free master connection.
// - Device keeps a consumer status for output data.
// - Eight DMA channels; channels 0 and 1 serve comm channel 0.
module pd_handshake #(
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Network side
  input wire logic net_rx_valid,
  input wire logic [DW-1:0] net_rx_data,
  input wire logic net_fault,
  input wire logic net_ok,
  input wire logic [7:0] remote_status,
  input wire logic [1:0] comm_channel,
  input wire logic out_processed,
  output logic [DW-1:0] net_tx_data,
  output logic net_tx_valid,
  // Attachment strap
  input wire logic pci_attached,
  // Status pins
  output logic communicating,
  output logic [2:0] in_dma_chan,
  output logic [2:0] out_dma_chan
);
  // ****************************************
  // Local state
  // ****************************************
  logic [DW-1:0] in_buf_q;
  logic [DW-1:0] in_img_q;
  logic [DW-1:0] out_img_q;
  logic host_in_q;
  logic host_out_q;
  logic dev_in_q;
  logic dev_out_q;
  logic master_q;
  logic gen_local_q;
  logic dma_req_q;
  logic [1:0] ssize_q;
  logic pci_q;
  logic cons_q;
  logic [7:0] in_ps;
  logic [7:0] out_ps_q;
  logic wr;
  logic rd;

  typedef enum {ST_IDLE, ST_COPY, ST_WAIT} copy_st_t;
  copy_st_t in_st_q;
  copy_st_t out_st_q;

  pd_copy_if #(.W(DW)) in_cp ();
  pd_copy_if #(.W(DW)) out_cp ();

  pd_copy_engine u_in_copy (
    .pclk(pclk),
    .presetn(presetn),
    .cp(in_cp)
  );
  pd_copy_engine u_out_copy (
    .pclk(pclk),
    .presetn(presetn),
    .cp(out_cp)
  );

  // Writes in the access phase, reads in the setup phase, zero wait states
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  // ****************************************
  // Strap capture
  // ****************************************
  // Caught after reset release, not as a reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pci_q <= 1'b0;
    end else begin
      pci_q <= pci_attached;
    end
  end

  // ****************************************
  // Configuration register
  // ****************************************
  // Status size only moves with the load bit set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_q <= 1'b0;
      gen_local_q <= 1'b1;
      dma_req_q <= 1'b0;
      ssize_q <= pd_pkg::SSIZE_NONE;
    end else if (wr && paddr == pd_pkg::ADDR_CTRL) begin
      master_q <= pwdata[pd_pkg::CTRL_MASTER];
      gen_local_q <= pwdata[pd_pkg::CTRL_GEN_LOCAL];
      dma_req_q <= pwdata[pd_pkg::CTRL_DMA_EN];
      if (pwdata[pd_pkg::CTRL_CFG_LOAD]) begin
        ssize_q <= pwdata[pd_pkg::CTRL_SSIZE_LO +: 2];
      end
    end
  end

  // ****************************************
  // Host handshake bits and shared output image
  // ****************************************
  // Host writes the output image only while owning it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_in_q <= 1'b0;
      host_out_q <= 1'b0;
      out_img_q <= '0;
      out_ps_q <= 8'h00;
    end else if (wr) begin
      if (paddr == pd_pkg::ADDR_HSK) begin
        host_in_q <= pwdata[pd_pkg::HSK_IN];
        host_out_q <= pwdata[pd_pkg::HSK_OUT];
      end
      if (paddr == pd_pkg::ADDR_OUT_IMG && host_out_q == dev_out_q) begin
        out_img_q <= pwdata[DW-1:0];
      end
      if (paddr == pd_pkg::ADDR_OUT_PSTAT && host_out_q == dev_out_q) begin
        out_ps_q <= pwdata[7:0];
      end
    end
  end

  // ****************************************
  // Internal input buffer
  // ****************************************
  // Refreshed each valid cycle; slave fault freezes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_buf_q <= '0;
    end else if (net_rx_valid && !(net_fault && !master_q)) begin
      in_buf_q <= net_rx_data;
    end
  end

  // Communicating flag, cleared on fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      communicating <= 1'b0;
    end else begin
      communicating <= net_ok && !net_fault;
    end
  end

  // ****************************************
  // Input image handshake
  // ****************************************
  // Differing bits mean the device owns the image
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_st_q <= ST_IDLE;
      dev_in_q <= 1'b0;
    end else begin
      unique case (in_st_q)
        ST_IDLE: begin
          if (host_in_q != dev_in_q) begin
            in_st_q <= ST_COPY;
          end
        end
        ST_COPY: begin
          in_st_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (in_cp.done) begin
            dev_in_q <= host_in_q;
            in_st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end
  assign in_cp.start = (in_st_q == ST_COPY);
  assign in_cp.src = in_buf_q;
  assign in_img_q = in_cp.dst;

  // ****************************************
  // Output image handshake
  // ****************************************
  // Same scheme, independent of the input side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_st_q <= ST_IDLE;
      dev_out_q <= 1'b0;
    end else begin
      unique case (out_st_q)
        ST_IDLE: begin
          if (host_out_q != dev_out_q) begin
            out_st_q <= ST_COPY;
          end
        end
        ST_COPY: begin
          out_st_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (out_cp.done) begin
            dev_out_q <= host_out_q;
            out_st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end
  assign out_cp.start = (out_st_q == ST_COPY);
  assign out_cp.src = out_img_q;

  // ****************************************
  // Network transmit
  // ****************************************
  // Same word repeats until a new image lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_tx_data <= '0;
      net_tx_valid <= 1'b0;
    end else begin
      net_tx_data <= out_cp.dst;
      net_tx_valid <= 1'b1;
    end
  end

  // Consumer status for the output image
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cons_q <= 1'b0;
    end else begin
      cons_q <= out_processed;
    end
  end

  // ****************************************
  // DMA channel mapping
  // ****************************************
  // Two DMA channels per comm channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_dma_chan <= 3'h0;
      out_dma_chan <= 3'h1;
    end else begin
      in_dma_chan <= {comm_channel, 1'b0};
      out_dma_chan <= {comm_channel, 1'b1};
    end
  end

  // ****************************************
  // Input provider status
  // ****************************************
  // Low nibble left to the fieldbus, passed as zero here
  always_comb begin
    in_ps = 8'h00;
    if (gen_local_q) begin
      in_ps[pd_pkg::PS_GEN] = 1'b1;
      in_ps[pd_pkg::PS_PROV] = communicating;
      in_ps[pd_pkg::PS_DATA] = master_q ? net_ok : (net_ok && !net_fault);
    end else begin
      in_ps = {remote_status[7:4], 4'h0};
      in_ps[pd_pkg::PS_GEN] = 1'b0;
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  // Reads answer in the access phase; no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        pd_pkg::ADDR_CTRL: begin
          prdata[pd_pkg::CTRL_MASTER] <= master_q;
          prdata[pd_pkg::CTRL_GEN_LOCAL] <= gen_local_q;
          prdata[pd_pkg::CTRL_DMA_EN] <= dma_req_q && pci_q;
          prdata[pd_pkg::CTRL_SSIZE_LO +: 2] <= ssize_q;
        end
        pd_pkg::ADDR_HSK: begin
          prdata[pd_pkg::HSK_IN] <= host_in_q;
          prdata[pd_pkg::HSK_OUT] <= host_out_q;
        end
        pd_pkg::ADDR_STAT: begin
          prdata[pd_pkg::STAT_DEV_IN] <= dev_in_q;
          prdata[pd_pkg::STAT_DEV_OUT] <= dev_out_q;
          prdata[pd_pkg::STAT_COMM] <= communicating;
          prdata[pd_pkg::STAT_DMA_OK] <= pci_q;
        end
        pd_pkg::ADDR_IN_IMG: begin
          prdata[DW-1:0] <= in_img_q;
        end
        pd_pkg::ADDR_OUT_IMG: begin
          prdata[DW-1:0] <= out_img_q;
        end
        pd_pkg::ADDR_IN_PSTAT: begin
          if (ssize_q != pd_pkg::SSIZE_NONE) begin
            prdata[7:0] <= in_ps;
          end
        end
        pd_pkg::ADDR_OUT_PSTAT: begin
          if (ssize_q != pd_pkg::SSIZE_NONE) begin
            prdata[7:0] <= out_ps_q;
          end
        end
        pd_pkg::ADDR_DMA_MAP: begin
          prdata[5:0] <= {out_dma_chan, in_dma_chan};
        end
        pd_pkg::ADDR_CONS: begin
          prdata[0] <= cons_q;
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Ready and error, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > pd_pkg::ADDR_CONS || paddr[1:0] != 2'h0);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_IN_RETURN: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(host_in_q != dev_in_q) |-> ##[1:4] (host_in_q == dev_in_q))
    else $error("input handshake not returned");
  AST_IN_COPY: assert property (@(posedge pclk) disable iff (!presetn)
    in_cp.start |=> (in_img_q == $past(in_buf_q)))
    else $error("input image not copied");
  AST_OUT_COPY: assert property (@(posedge pclk) disable iff (!presetn)
    out_cp.start |=> (out_cp.dst == $past(out_img_q)))
    else $error("output image not copied");
  AST_TX_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !out_cp.done ##1 !out_cp.done |-> $stable(net_tx_data))
    else $error("tx data changed without new image");
  AST_FAULT_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
    (net_fault && !master_q) |=> (in_buf_q == $past(in_buf_q)))
    else $error("input changed during slave fault");
  AST_COMM_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    net_fault |=> !communicating)
    else $error("communicating not cleared");
  AST_DMA_MAP: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (out_dma_chan == in_dma_chan + 3'h1) && !in_dma_chan[0])
    else $error("dma mapping wrong");
  AST_SSIZE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && paddr == pd_pkg::ADDR_CTRL && pwdata[pd_pkg::CTRL_CFG_LOAD]) |=> $stable(ssize_q))
    else $error("status size changed without load");
  AST_RX_UPDATE: assert property (@(posedge pclk) disable iff (!presetn)
    (net_rx_valid && !net_fault) |=> (in_buf_q == $past(net_rx_data)))
    else $error("input buffer not refreshed");
endmodule

//--- hdl/pd_pkg.sv
// Purpose: shared constants for the process data handshake block
// Assumes: 32-bit APB, one word per register
// Notes: offsets are byte addresses
package pd_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HSK = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_IN_IMG = 8'h0C;
  localparam logic [7:0] ADDR_OUT_IMG = 8'h10;
  localparam logic [7:0] ADDR_IN_PSTAT = 8'h14;
  localparam logic [7:0] ADDR_OUT_PSTAT = 8'h18;
  localparam logic [7:0] ADDR_DMA_MAP = 8'h1C;
  localparam logic [7:0] ADDR_CONS = 8'h20;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_GEN_LOCAL = 1;
  localparam int CTRL_DMA_EN = 2;
  localparam int CTRL_CFG_LOAD = 3;
  localparam int CTRL_SSIZE_LO = 4;
  localparam int HSK_IN = 0;
  localparam int HSK_OUT = 1;
  localparam int STAT_DEV_IN = 0;
  localparam int STAT_DEV_OUT = 1;
  localparam int STAT_COMM = 2;
  localparam int STAT_DMA_OK = 3;
  localparam int PS_GEN = 5;
  localparam int PS_PROV = 6;
  localparam int PS_DATA = 7;
  // Status field size codes
  localparam logic [1:0] SSIZE_NONE = 2'h0;
  localparam logic [1:0] SSIZE_BYTE = 2'h1;
  localparam logic [1:0] SSIZE_WORD = 2'h2;
  localparam int NUM_COMM = 4;
  localparam int NUM_DMA = 8;
endpackage

//--- hdl/pd_copy_if.sv
// Purpose: carries one image copy request and its completion
// Assumes: single clock
// Notes: start is a one-cycle pulse
interface pd_copy_if #(parameter int W = 32);
  logic start;
  logic done;
  logic [W-1:0] src;
  logic [W-1:0] dst;
  modport ctl (output start, output src, input done, input dst);
  modport eng (input start, input src, output done, output dst);
endinterface

//--- hdl/pd_copy_engine.sv
// Purpose: copies one image into a holding register on request
// Assumes: pclk domain only
// Notes: one cycle per copy, done one cycle after start
module pd_copy_engine (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Copy port
  pd_copy_if.eng cp
);
  // Capture source on start, pulse done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cp.dst <= '0;
      cp.done <= 1'b0;
    end else begin
      cp.done <= cp.start;
      if (cp.start) begin
        cp.dst <= cp.src;
      end
    end
  end
endmodule

//--- sim/pd_host_model.sv
// Purpose: host driver model speaking APB to the handshake block
// Assumes: slave answers with pready in its own time
// Notes: released address and data lines show inverted values
module pd_host_model (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // ****
  // Transfers
  // ****
  // Request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; the bench watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;  // Never leave the old value standing
    pwdata <= ~d;
  endtask

  // Wait, bounded, until the device bit matches the host bit
  task automatic poll(input int b, input logic hb, output logic ok);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, pd_pkg::ADDR_STAT, 32'h0000_0000, r, e);
      n++;
    end while (r[b] !== hb && n < 20);
    ok = (r[b] === hb);
  endtask

  // Release an image by toggling its bit, then wait for it back
  task automatic hsk(input int b, output logic ok);
    logic [31:0] r;
    logic [31:0] q;
    logic e;
    apb(1'b0, pd_pkg::ADDR_HSK, 32'h0000_0000, r, e);
    r = r ^ (32'h0000_0001 << b);
    apb(1'b1, pd_pkg::ADDR_HSK, r, q, e);
    poll(b, r[b], ok);
  endtask
endmodule

//--- sim/tb_buffered_process_data_handshake.sv
// Purpose: self-checking bench for the process data handshake block
// Assumes: APB slave answers one cycle after setup
// Notes: table rows cover channel map; handshakes are hand-written
module tb_buffered_process_data_handshake;
  timeunit 1ns;
  timeprecision 1ns;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, net_tx_data;
  logic net_rx_valid = 1'b0;
  logic [31:0] net_rx_data = 32'h0000_0000;
  logic net_fault = 1'b0;
  logic net_ok = 1'b1;
  logic [7:0] remote_status = 8'h00;
  logic [1:0] comm_channel = 2'h0;
  logic out_processed = 1'b0;
  logic pci_attached = 1'b0;
  logic net_tx_valid, communicating;
  logic [2:0] in_dma_chan, out_dma_chan;
  int errors = 0;
  int n_checks = 0;

  typedef struct packed {
    logic [1:0] ch;
    logic pci;
    logic prc;
    logic [2:0] in_c;
    logic [2:0] out_c;
  } row_t;
  row_t rows [4] = '{'{2'h0, 1'b0, 1'b1, 3'h0, 3'h1}, '{2'h1, 1'b1, 1'b0, 3'h2, 3'h3},
                     '{2'h2, 1'b0, 1'b0, 3'h4, 3'h5}, '{2'h3, 1'b1, 1'b1, 3'h6, 3'h7}};

  // 20 MHz clock
  always #25 pclk = ~pclk;

  pd_handshake i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .net_rx_valid(net_rx_valid), .net_rx_data(net_rx_data), .net_fault(net_fault),
    .net_ok(net_ok), .remote_status(remote_status), .comm_channel(comm_channel),
    .out_processed(out_processed), .net_tx_data(net_tx_data), .net_tx_valid(net_tx_valid),
    .pci_attached(pci_attached), .communicating(communicating),
    .in_dma_chan(in_dma_chan), .out_dma_chan(out_dma_chan));

  pd_host_model i_host (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ****
  // Helpers
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    i_host.apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic e;
    i_host.apb(1'b0, a, 32'h0000_0000, v, e);
  endtask

  task automatic xchg(input int b);
    logic ok;
    i_host.hsk(b, ok);
    chk(32'(ok), 32'h0000_0001, "device bit not back");
  endtask

  // Exchange an input image, then compare its provider status
  task automatic pstat(input logic [31:0] exp);
    logic [31:0] v;
    xchg(pd_pkg::HSK_IN);
    rd(pd_pkg::ADDR_IN_PSTAT, v);
    chk(v, exp, "input status");
  endtask

  task automatic complete_run;
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole sequence needs a few hundred cycles at most
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    complete_run();
  end

  // ****
  // Main sequence
  // ****
  initial begin
    logic [31:0] v;
    logic e;
    logic ok;
    repeat (12) @(posedge pclk);
    chk(32'(out_dma_chan), 32'h0000_0001, "reset out chan");
    chk(32'({net_tx_valid, communicating, pready, in_dma_chan}), 32'h0000_0000, "reset outs");
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'(net_tx_valid), 32'h0000_0001, "tx not running");
    rd(pd_pkg::ADDR_CTRL, v);
    chk(v, 32'h0000_0002, "ctrl reset");
    rd(pd_pkg::ADDR_STAT, v);
    chk(v, 32'h0000_0004, "stat reset");
    wr(pd_pkg::ADDR_CTRL, 32'h0000_0006);
    foreach (rows[i]) begin
      comm_channel <= rows[i].ch;
      pci_attached <= rows[i].pci;
      out_processed <= rows[i].prc;
      repeat (2) @(posedge pclk);
      chk(32'(in_dma_chan), 32'(rows[i].in_c), "in chan");
      chk(32'(out_dma_chan), 32'(rows[i].out_c), "out chan");
      rd(pd_pkg::ADDR_STAT, v);
      chk(32'(v[pd_pkg::STAT_DMA_OK]), 32'(rows[i].pci), "dma offer");
      rd(pd_pkg::ADDR_CONS, v);
      chk(32'(v[0]), 32'(rows[i].prc), "consumer");
      rd(pd_pkg::ADDR_CTRL, v);
      chk(32'(v[pd_pkg::CTRL_DMA_EN]), 32'(rows[i].pci), "dma grant");
      rd(pd_pkg::ADDR_DMA_MAP, v);
      chk(v, 32'({rows[i].out_c, rows[i].in_c}), "dma map reg");
    end
    // Two words arrive; only the latest must reach the image
    net_rx_data <= 32'h1111_2222;
    net_rx_valid <= 1'b1;
    @(posedge pclk);
    net_rx_data <= 32'h3333_4444;
    @(posedge pclk);
    net_rx_valid <= 1'b0;
    xchg(pd_pkg::HSK_IN);
    rd(pd_pkg::ADDR_IN_IMG, v);
    chk(v, 32'h3333_4444, "latest input");
    rd(pd_pkg::ADDR_STAT, v);
    chk(32'(v[1:0]), 32'h0000_0001, "output side moved");
    // Output toggle, then a write while the device owns the image
    wr(pd_pkg::ADDR_OUT_IMG, 32'hA5A5_0001);
    wr(pd_pkg::ADDR_HSK, 32'h0000_0003);
    wr(pd_pkg::ADDR_OUT_IMG, 32'hDEAD_0002);
    i_host.poll(pd_pkg::HSK_OUT, 1'b1, ok);
    chk(32'(ok), 32'h0000_0001, "out bit not back");
    rd(pd_pkg::ADDR_OUT_IMG, v);
    chk(v, 32'hA5A5_0001, "write while device owned");
    repeat (3) @(posedge pclk);
    chk(net_tx_data, 32'hA5A5_0001, "tx copy");
    repeat (20) @(posedge pclk);
    chk(net_tx_data, 32'hA5A5_0001, "tx repeat");
    // Slave, local status, one byte, loaded
    wr(pd_pkg::ADDR_CTRL, 32'h0000_001A);
    pstat(32'h0000_00E0);
    net_fault <= 1'b1;
    net_rx_data <= 32'h7777_0000;
    net_rx_valid <= 1'b1;
    @(posedge pclk);
    net_rx_valid <= 1'b0;
    pstat(32'h0000_0020);
    rd(pd_pkg::ADDR_IN_IMG, v);
    chk(v, 32'h3333_4444, "input not frozen");
    chk(32'(communicating), 32'h0000_0000, "still communicating");
    // Master, local then remote status
    net_fault <= 1'b0;
    net_ok <= 1'b0;
    wr(pd_pkg::ADDR_CTRL, 32'h0000_0013);
    pstat(32'h0000_0020);
    net_ok <= 1'b1;
    pstat(32'h0000_00E0);
    remote_status <= 8'hC5;
    wr(pd_pkg::ADDR_CTRL, 32'h0000_0011);
    pstat(32'h0000_00C0);
    // Size holds until a configuration load
    wr(pd_pkg::ADDR_OUT_PSTAT, 32'h0000_00C0);
    wr(pd_pkg::ADDR_CTRL, 32'h0000_0001);
    rd(pd_pkg::ADDR_OUT_PSTAT, v);
    chk(v, 32'h0000_00C0, "size changed early");
    wr(pd_pkg::ADDR_CTRL, 32'h0000_0009);
    rd(pd_pkg::ADDR_OUT_PSTAT, v);
    chk(v, 32'h0000_0000, "size not removed");
    // Unmapped address answers with an error and zero
    i_host.apb(1'b0, 8'h24, 32'h0000_0000, v, e);
    chk({v[30:0], e}, 32'h0000_0001, "unmapped");
    complete_run();
  end
endmodule
